/* rtl/burst_counter.sv */
`timescale 1ns/10ps
`default_nettype none
module burst_counter (
  // clock and reset
  input  wire logic                             clk_sys,
  input  wire logic                             nrst,
  // controls
  input  wire logic                             address_strobe_n,
  input  wire logic                             count_advance_n,
  input  wire logic                             count_clear_n,
  input  wire logic [dpram_pkg::addr_width-1:0] addr,
  // access address and counter
  output logic      [dpram_pkg::addr_width-1:0] access_addr,
  output logic      [dpram_pkg::addr_width-1:0] count_q
);
  typedef struct packed {
    logic [dpram_pkg::addr_width-1:0] count;
  } state_type;
  state_type s_q;
  state_type s_d;
  always_comb begin
    s_d = s_q;
    access_addr = s_q.count;
    if (!count_clear_n) begin
      s_d.count = '0;
      access_addr = '0;
    end else if (!address_strobe_n) begin
      access_addr = addr;
      if (!count_advance_n) begin
        s_d.count = addr;
      end
    end else if (!count_advance_n) begin
      s_d.count = s_q.count + {{(dpram_pkg::addr_width-1){1'b0}}, 1'b1};
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign count_q = s_q.count;
endmodule : burst_counter
`default_nettype wire

/* rtl/dpram_device.sv */
`timescale 1ns/10ps
`default_nettype none
module dpram_device (
  // clocks and resets
  input  wire logic clk_left,
  input  wire logic nrst_left,
  input  wire logic clk_right,
  input  wire logic nrst_right,
  // ports
  dpram_port_if.device left_port,
  dpram_port_if.device right_port
);
  localparam int depth = 1 << dpram_pkg::addr_width;
  logic [dpram_pkg::data_width-1:0] mem [0:depth-1];
  logic [dpram_pkg::addr_width-1:0] addr_l, addr_r;
  logic [dpram_pkg::data_width-1:0] rd_l_q, rd_r_q, pipe_l_q, pipe_r_q;
  logic [dpram_pkg::lane_count-1:0] lanes_l_q, lanes_l_p;
  logic on_l_q, on_r_q, on_l_p, on_r_p;
  burst_counter u_cnt_l (
    .clk_sys(clk_left), .nrst(nrst_left),
    .address_strobe_n(left_port.address_strobe_n),
    .count_advance_n(left_port.count_advance_n),
    .count_clear_n(left_port.count_clear_n),
    .addr(left_port.addr), .access_addr(addr_l), .count_q());
  burst_counter u_cnt_r (
    .clk_sys(clk_right), .nrst(nrst_right),
    .address_strobe_n(right_port.address_strobe_n),
    .count_advance_n(right_port.count_advance_n),
    .count_clear_n(right_port.count_clear_n),
    .addr(right_port.addr), .access_addr(addr_r), .count_q());
  // left port with byte lanes
  always @(posedge clk_left) begin
    if (!left_port.chip_enable_n && !left_port.read_write) begin
      for (int i = 0; i < dpram_pkg::lane_count; i++) begin
        if (left_port.byte_lane_select[i]) begin
          mem[addr_l][i*dpram_pkg::lane_width +: dpram_pkg::lane_width] <=
            left_port.data_host[i*dpram_pkg::lane_width +: dpram_pkg::lane_width];
        end
      end
    end
  end
  always_ff @(posedge clk_left) begin
    if (!nrst_left) begin
      rd_l_q <= '0; pipe_l_q <= '0; on_l_q <= 1'b0; on_l_p <= 1'b0;
      lanes_l_q <= '0; lanes_l_p <= '0;
    end else begin
      rd_l_q    <= mem[addr_l];
      on_l_q    <= !left_port.chip_enable_n && left_port.read_write;
      lanes_l_q <= left_port.byte_lane_select;
      pipe_l_q  <= rd_l_q;
      on_l_p    <= on_l_q;
      lanes_l_p <= lanes_l_q;
    end
  end
  // right port full word
  always @(posedge clk_right) begin
    if (!right_port.chip_enable_n && !right_port.read_write) begin
      mem[addr_r] <= right_port.data_host;
    end
  end
  always_ff @(posedge clk_right) begin
    if (!nrst_right) begin
      rd_r_q <= '0; pipe_r_q <= '0; on_r_q <= 1'b0; on_r_p <= 1'b0;
    end else begin
      rd_r_q   <= mem[addr_r];
      on_r_q   <= !right_port.chip_enable_n && right_port.read_write;
      pipe_r_q <= rd_r_q;
      on_r_p   <= on_r_q;
    end
  end
  // output drive
  logic [dpram_pkg::data_width-1:0] lmask;
  always_comb begin
    lmask = '0;
    for (int i = 0; i < dpram_pkg::lane_count; i++) begin
      lmask[i*dpram_pkg::lane_width +: dpram_pkg::lane_width] =
        {dpram_pkg::lane_width{left_port.output_mode_select ? lanes_l_p[i] : lanes_l_q[i]}};
    end
  end
  assign left_port.data_dev = (left_port.output_mode_select ? pipe_l_q : rd_l_q) & lmask;
  assign left_port.data_dev_oe = !left_port.output_enable_n &&
    (left_port.output_mode_select ? on_l_p : on_l_q);
  assign right_port.data_dev = right_port.output_mode_select ? pipe_r_q : rd_r_q;
  assign right_port.data_dev_oe = !right_port.output_enable_n &&
    (right_port.output_mode_select ? on_r_p : on_r_q);
endmodule : dpram_device
`default_nettype wire

/* rtl/dpram_host.sv */
`timescale 1ns/10ps
`default_nettype none
module dpram_host (
  // clock and reset
  input  wire logic                             clk_sys,
  input  wire logic                             nrst,
  // user commands
  input  wire logic                             cmd_valid,
  input  wire logic                             cmd_write,
  input  wire logic                             cmd_burst,
  input  wire logic                             cmd_clear,
  input  wire logic                             cmd_pipelined,
  input  wire logic [dpram_pkg::lane_count-1:0] cmd_lanes,
  input  wire logic [dpram_pkg::addr_width-1:0] cmd_addr,
  input  wire logic [dpram_pkg::data_width-1:0] cmd_wdata,
  // read return
  output logic      [dpram_pkg::data_width-1:0] rdata_q,
  // port
  dpram_port_if.host port
);
  typedef struct packed {
    logic [dpram_pkg::addr_width-1:0] addr;
    logic                             ads_n, adv_n, clr_n, ce_n, oe_n, rw, mode;
    logic [dpram_pkg::lane_count-1:0] lanes;
    logic [dpram_pkg::data_width-1:0] wdata;
    logic                             drive;
    logic [dpram_pkg::data_width-1:0] rdata;
  } state_type;
  state_type s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.ads_n = 1'b1; s_d.adv_n = 1'b1; s_d.clr_n = 1'b1; s_d.ce_n = 1'b1;
    s_d.drive = 1'b0;
    s_d.mode = cmd_pipelined;
    if (port.data_dev_oe) s_d.rdata = port.data_dev;
    if (cmd_valid) begin
      s_d.ce_n  = 1'b0;
      s_d.clr_n = !cmd_clear;
      s_d.ads_n = cmd_burst;
      s_d.adv_n = 1'b0;
      s_d.rw    = !cmd_write;
      s_d.oe_n  = cmd_write;
      s_d.drive = cmd_write;
      s_d.lanes = cmd_lanes;
      s_d.addr  = cmd_addr;
      s_d.wdata = cmd_wdata;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_q <= '{default: '0, ads_n: 1'b1, adv_n: 1'b1, clr_n: 1'b1,
               ce_n: 1'b1, oe_n: 1'b1, rw: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end
  assign port.addr = s_q.addr;
  assign port.address_strobe_n = s_q.ads_n;
  assign port.count_advance_n = s_q.adv_n;
  assign port.count_clear_n = s_q.clr_n;
  assign port.chip_enable_n = s_q.ce_n;
  assign port.output_enable_n = s_q.oe_n;
  assign port.read_write = s_q.rw;
  assign port.output_mode_select = s_q.mode;
  assign port.byte_lane_select = s_q.lanes;
  assign port.data_host = s_q.wdata;
  assign port.data_host_oe = s_q.drive;
  assign rdata_q = s_q.rdata;
endmodule : dpram_host
`default_nettype wire

/* rtl/dpram_pkg.sv */
// Contract
// - strobe low selects external address this cycle
// - load counter when strobe and advance low
// - clear low makes strobe ignored
// - advance low increments counter every edge
// - clear low makes advance ignored
// - clear low sets counter to zero
// - clear beats load and increment
// - data driven only on read with oe low
// - rw low writes, high reads
// - mode low flow-through, high pipelined output
// - left byte lanes gate reads and writes
// - state holds without clock edges
// - counter wraps to zero past last word
// - chip enable high powers port down; counter still loads, advances and clears, only writes and read drive stop
package dpram_pkg;
  localparam int addr_width     = 14;
  localparam int data_width     = 36;
  localparam int lane_count     = 4;
  localparam int lane_width     = 9;
  localparam logic [1:0] mode_flow_through = 2'h0;
endpackage : dpram_pkg

/* rtl/dpram_port_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface dpram_port_if;
  logic [dpram_pkg::addr_width-1:0] addr;
  logic                             address_strobe_n;
  logic                             count_advance_n;
  logic                             count_clear_n;
  logic                             chip_enable_n;
  logic                             output_enable_n;
  logic                             read_write;
  logic                             output_mode_select;
  logic [dpram_pkg::lane_count-1:0] byte_lane_select;
  logic [dpram_pkg::data_width-1:0] data_host;
  logic                             data_host_oe;
  logic [dpram_pkg::data_width-1:0] data_dev;
  logic                             data_dev_oe;
  modport device (
    input  addr, address_strobe_n, count_advance_n, count_clear_n, chip_enable_n,
    input  output_enable_n, read_write, output_mode_select, byte_lane_select,
    input  data_host, data_host_oe,
    output data_dev, data_dev_oe
  );
  modport host (
    output addr, address_strobe_n, count_advance_n, count_clear_n, chip_enable_n,
    output output_enable_n, read_write, output_mode_select, byte_lane_select,
    output data_host, data_host_oe,
    input  data_dev, data_dev_oe
  );
endinterface : dpram_port_if
`default_nettype wire

/* test/dpram_port_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module dpram_port_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // port pins
  input wire logic address_strobe_n,
  input wire logic count_advance_n,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic read_write,
  input wire logic data_host_oe,
  input wire logic data_dev_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  oe_off_a: assert property (output_enable_n |-> !data_dev_oe) else $error("dev drives, oe high");
  no_fight_a: assert property (!(data_host_oe && data_dev_oe)) else $error("both drive data");
  host_write_a: assert property (data_host_oe |-> !read_write && !chip_enable_n)
    else $error("host drives outside write");
  read_late_a: assert property (data_dev_oe |-> $past(!chip_enable_n && read_write)
    || $past(!chip_enable_n && read_write, 2)) else $error("read data without read");
  strobe_load_a: assert property (!address_strobe_n |-> !count_advance_n)
    else $error("strobe without advance");
  strobe_ce_a: assert property (!address_strobe_n |-> !chip_enable_n)
    else $error("strobe without chip enable");
  down_quiet_a: assert property ($past(chip_enable_n) && $past(chip_enable_n, 2) |-> !data_dev_oe)
    else $error("data while powered down");
  reset_idle_a: assert property (disable iff (1'b0) !nrst |=> chip_enable_n && address_strobe_n
    && output_enable_n && read_write) else $error("pins not idle after reset");
endmodule // dpram_port_chk
`default_nettype wire

/* test/dual_port_sram_port_burst_counter_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module dual_port_sram_port_burst_counter_tb;
  logic        clk_sys, nrst, v_l, v_r, wr, bu, cl, pi;
  logic        rb, rw, rc;
  int          rp;
  logic [3:0]  ln;
  logic [13:0] ad;
  logic [35:0] wd, rd_l, rd_r;
  logic [35:0] mem [int];
  logic [13:0] al [6] = '{14'h0, 14'h1, 14'h2, 14'h3, 14'h3ffe, 14'h3fff};
  int          miscompares, compares, seed, i, cnt [2];
  dpram_port_if if_l ();
  dpram_port_if if_r ();
  dpram_device u_dpram_device (.clk_left(clk_sys), .nrst_left(nrst), .clk_right(clk_sys),
    .nrst_right(nrst), .left_port(if_l), .right_port(if_r));
  dpram_host u_dpram_host_l (.clk_sys(clk_sys), .nrst(nrst), .cmd_valid(v_l), .cmd_write(wr),
    .cmd_burst(bu), .cmd_clear(cl), .cmd_pipelined(pi), .cmd_lanes(ln), .cmd_addr(ad),
    .cmd_wdata(wd), .rdata_q(rd_l), .port(if_l));
  dpram_host u_dpram_host_r (.clk_sys(clk_sys), .nrst(nrst), .cmd_valid(v_r), .cmd_write(wr),
    .cmd_burst(bu), .cmd_clear(cl), .cmd_pipelined(pi), .cmd_lanes(ln), .cmd_addr(ad),
    .cmd_wdata(wd), .rdata_q(rd_r), .port(if_r));
  dpram_port_chk u_dpram_port_chk (.clk_sys(clk_sys), .nrst(nrst),
    .address_strobe_n(if_l.address_strobe_n), .count_advance_n(if_l.count_advance_n),
    .chip_enable_n(if_l.chip_enable_n), .output_enable_n(if_l.output_enable_n),
    .read_write(if_l.read_write), .data_host_oe(if_l.data_host_oe),
    .data_dev_oe(if_l.data_dev_oe));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task stop_test;
    $display("miscompares %0d compares %0d", miscompares, compares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task check36(input string n, input logic [35:0] e, input logic [35:0] s);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task op(input int p, input logic w, input logic b, input logic c, input logic [3:0] l,
          input logic [13:0] a);
    logic [35:0] m, d;
    int x;
    for (int k = 0; k < 4; k++) m[9*k +: 9] = (p == 1 || l[k]) ? 9'h1ff : 9'h0;
    d = {$random(seed), $random(seed)};
    x = c ? 0 : (b ? cnt[p] : a);
    cnt[p] = c ? 0 : (b ? (x + 1) % (1 << 14) : a);
    @(posedge clk_sys);
    wr <= w;
    bu <= b;
    cl <= c;
    ln <= l;
    ad <= a;
    wd <= d;
    pi <= $random(seed);
    v_l <= p == 0;
    v_r <= p == 1;
    @(posedge clk_sys);
    v_l <= 1'b0;
    v_r <= 1'b0;
    if (w) mem[x] = (mem[x] & ~m) | (d & m);
    repeat (6) @(posedge clk_sys);
    if (!w) check36("rdata", mem[x] & m, p ? rd_r : rd_l);
  endtask
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    #1000000;
    miscompares++;
    stop_test;
  end
  initial begin
    {nrst, v_l, v_r, wr, bu, cl, pi, ln, ad, wd} = '0;
    seed = 32'h8b8e2eb0;
    cnt = '{0, 0};
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    for (i = 0; i < 6; i++) op(0, 1, 0, 0, 4'hf, al[i]);
    op(0, 1, 0, 0, 4'hf, 14'h3ffe);
    op(0, 1, 1, 0, 4'hf, 14'h0);
    op(0, 1, 1, 0, 4'hf, 14'h5);
    op(0, 0, 1, 0, 4'hf, 14'h5);
    for (i = 3; i < 6; i++) op(1, 0, 0, 0, 4'h0, al[i]);
    op(0, 0, 0, 1, 4'hf, 14'h3);
    op(0, 0, 1, 0, 4'hf, 14'h3);
    for (i = 0; i < 80; i++) begin
      rb = $random(seed);
      rw = $random(seed);
      rp = {$random(seed)} % 2;
      if (!mem.exists(cnt[rp])) rb = 1'b0;
      rc = !rw && ($random(seed) % 4 == 0);
      op(rp, rw, rb, rc, $random(seed), al[{$random(seed)} % 6]);
    end
    stop_test;
  end
endmodule // dual_port_sram_port_burst_counter_tb
`default_nettype wire
